// ### maa_mem_model.sv
// Purpose: behavioural core memory answering cycle starts
// Assumes: one shared done line for all modules
// Notes: slow stretches the answer so the wait for done is seen
`timescale 1ns/1ps
`default_nettype none
module maa_mem_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// memory side
	input wire logic cycleStart,
	input wire logic slow,
	output logic memDone
);
	logic [2:0] waitCnt;
	// done held until start drops, then released at once
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt <= 3'h0;
			memDone <= 1'b0;
		end else if (!cycleStart) begin
			waitCnt <= 3'h0;
			memDone <= 1'b0;
		end else if (waitCnt == (slow ? 3'h5 : 3'h1)) begin
			memDone <= 1'b1;
		end else begin
			waitCnt <= waitCnt + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ### maa_memory_access_arbiter.sv
// Purpose: grants one of two processors on a shared port access to core memory
// Assumes: requests, launches and memory done arrive without phase relation
// Notes: io_processor outranks central_processor; one access per grant
`timescale 1ns/1ps
`default_nettype none

// Operation
// - address-select grant goes only to the processor that memory is free for.
// - no fixed delay after grant; arbiter waits for the processor's launch.
// - claim inputs are synchronised before use, no phase assumed.
// - two processors share the port; only one uses memory at once.
// - dedicated signal tells the owner it alone holds the data bus.
// - others blocked until the granted processor starts and finishes its access.
// - on simultaneous claims the io_processor wins over the central_processor.
// - each processor has its own module base and allowed-module set.
// - 17-bit address splits into 4-bit module and 13-bit cell index.
// - only the selected module sees the cell index and cycle start; here both go out on shared lines and one-hot modSelect marks the module.
// - selected module performs one read or modify access per launch.
// - decode covers one to sixteen modules of 8,192 cells each.
// - lowest 256 cells are system cells; access to them is flagged.
// - bits are numbered from the leftmost bit, starting at zero.
// - a word is one cell; smaller units sit aligned inside one cell.
// - a doubleword may use any two consecutive cells.
// - simultaneous claims are resolved to exactly one grant.
module maa_memory_access_arbiter (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// io_processor side
	input wire logic ioReq,
	input wire logic ioLaunch,
	input wire logic ioWrite,
	input wire logic [maa_pkg::ADDR_W-1:0] ioAddr,
	input wire logic [maa_pkg::MOD_W-1:0] ioModBase,
	input wire logic [maa_pkg::NUM_MODULES-1:0] ioModAllow,
	output logic ioGrant,
	output logic ioBusOwn,
	// central_processor side
	input wire logic cpReq,
	input wire logic cpLaunch,
	input wire logic cpWrite,
	input wire logic [maa_pkg::ADDR_W-1:0] cpAddr,
	input wire logic [maa_pkg::MOD_W-1:0] cpModBase,
	input wire logic [maa_pkg::NUM_MODULES-1:0] cpModAllow,
	output logic cpGrant,
	output logic cpBusOwn,
	// memory modules
	input wire logic [maa_pkg::NUM_MODULES-1:0] modPresent,
	input wire logic memDone,
	output logic [maa_pkg::NUM_MODULES-1:0] modSelect,
	output logic [maa_pkg::CELL_W-1:0] cellIndex,
	output logic cycleStart,
	output logic writeOp,
	// status
	output logic sysCellHit,
	output logic addrFault
);
	import maa_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic ioReqS1;
		logic ioReqS2;
		logic cpReqS1;
		logic cpReqS2;
		logic ioLaunchS1;
		logic ioLaunchS2;
		logic cpLaunchS1;
		logic cpLaunchS2;
		logic doneS1;
		logic doneS2;
		maa_state_e state;
		logic ownerIo;
		logic ioGrant;
		logic cpGrant;
		logic ioBusOwn;
		logic cpBusOwn;
		logic [NUM_MODULES-1:0] modSelect;
		logic [CELL_W-1:0] cellIndex;
		logic cycleStart;
		logic writeOp;
		logic sysCellHit;
		logic addrFault;
	} maa_regs_s;

	maa_regs_s r_ff;
	maa_regs_s nxt_r;

	// ----------------------------------------
	// owner address decode
	// ----------------------------------------
	logic [ADDR_W-1:0] ownAddr;
	logic [MOD_W-1:0] logMod;
	logic [MOD_W-1:0] physMod;
	logic modOk;
	logic ownLaunch;
	logic ownReq;

	always_comb begin
		ownAddr = r_ff.ownerIo ? ioAddr : cpAddr;
		// leftmost four bits (field bits 0..3) pick the module; no alignment
		// check, so a doubleword may straddle two modules
		logMod = ownAddr[MOD_MSB:MOD_LSB];
		// per-processor relocation; wraps modulo sixteen modules
		physMod = r_ff.ownerIo ? MOD_W'(logMod + ioModBase) : MOD_W'(logMod + cpModBase);
		modOk = (r_ff.ownerIo ? ioModAllow[logMod] : cpModAllow[logMod]) && modPresent[physMod];
		ownLaunch = r_ff.ownerIo ? r_ff.ioLaunchS2 : r_ff.cpLaunchS2;
		ownReq = r_ff.ownerIo ? r_ff.ioReqS2 : r_ff.cpReqS2;
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_r = r_ff;
		// synchronisers: stage one is read only by stage two
		nxt_r.ioReqS1 = ioReq;
		nxt_r.ioReqS2 = r_ff.ioReqS1;
		nxt_r.cpReqS1 = cpReq;
		nxt_r.cpReqS2 = r_ff.cpReqS1;
		nxt_r.ioLaunchS1 = ioLaunch;
		nxt_r.ioLaunchS2 = r_ff.ioLaunchS1;
		nxt_r.cpLaunchS1 = cpLaunch;
		nxt_r.cpLaunchS2 = r_ff.cpLaunchS1;
		nxt_r.doneS1 = memDone;
		nxt_r.doneS2 = r_ff.doneS1;
		nxt_r.addrFault = 1'b0;
		unique case (r_ff.state)
			ST_IDLE: begin
				if (r_ff.ioReqS2) begin
					// fixed priority, io first
					nxt_r.ownerIo = 1'b1;
					nxt_r.ioGrant = 1'b1;
					nxt_r.ioBusOwn = 1'b1;
					nxt_r.state = ST_GRANT;
				end else if (r_ff.cpReqS2) begin
					nxt_r.ownerIo = 1'b0;
					nxt_r.cpGrant = 1'b1;
					nxt_r.cpBusOwn = 1'b1;
					nxt_r.state = ST_GRANT;
				end
			end
			ST_GRANT: begin
				// no timeout: the processor alone paces the transfer
				if (ownLaunch) begin
					if (modOk) begin
						nxt_r.modSelect = NUM_MODULES'(1) << physMod;
						nxt_r.cellIndex = ownAddr[CELL_W-1:0];
						nxt_r.cycleStart = 1'b1;
						nxt_r.writeOp = r_ff.ownerIo ? ioWrite : cpWrite;
						nxt_r.sysCellHit = ownAddr < RESERVED_CELLS;
						nxt_r.state = ST_BUSY;
					end else begin
						// unmapped module: no cycle, grant is dropped
						nxt_r.addrFault = 1'b1;
						nxt_r.state = ST_RELEASE;
					end
				end
			end
			ST_BUSY: begin
				// memory stays exclusive until the module reports done
				if (r_ff.doneS2) begin
					nxt_r.cycleStart = 1'b0;
					nxt_r.modSelect = RST_MODSEL;
					nxt_r.state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				nxt_r.ioGrant = 1'b0;
				nxt_r.cpGrant = 1'b0;
				// wait for the handshake to return to rest so a stale
				// claim or launch is never taken as a new one
				if (!ownReq && !ownLaunch && !r_ff.doneS2) begin
					nxt_r.ioBusOwn = 1'b0;
					nxt_r.cpBusOwn = 1'b0;
					nxt_r.sysCellHit = 1'b0;
					nxt_r.state = ST_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_ff <= '{
				state: ST_IDLE,
				modSelect: RST_MODSEL,
				cellIndex: RST_CELL,
				default: 1'b0
			};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign ioGrant = r_ff.ioGrant;
	assign cpGrant = r_ff.cpGrant;
	assign ioBusOwn = r_ff.ioBusOwn;
	assign cpBusOwn = r_ff.cpBusOwn;
	assign modSelect = r_ff.modSelect;
	assign cellIndex = r_ff.cellIndex;
	assign cycleStart = r_ff.cycleStart;
	assign writeOp = r_ff.writeOp;
	assign sysCellHit = r_ff.sysCellHit;
	assign addrFault = r_ff.addrFault;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	logic [ADDR_W-1:0] srcAddrChk;
	assign srcAddrChk = ownAddr;

	sequence seq_launchTaken;
		r_ff.state == ST_GRANT && ownLaunch && modOk;
	endsequence

	sequence seq_memDone;
		r_ff.state == ST_BUSY && r_ff.doneS2;
	endsequence

	sequence seq_launchFault;
		r_ff.state == ST_GRANT && ownLaunch && !modOk;
	endsequence

	sequence seq_releaseHeld;
		r_ff.state == ST_RELEASE && (ownReq || ownLaunch || r_ff.doneS2);
	endsequence

	sequence seq_quietIdle;
		r_ff.state == ST_IDLE && !$past(ioReq) && !$past(cpReq) && !r_ff.ioReqS2 && !r_ff.cpReqS2;
	endsequence

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	a_single_grant: assert property (!(ioGrant && cpGrant))
		else $error("both processors granted");

	a_io_priority: assert property (
		r_ff.state == ST_IDLE && r_ff.ioReqS2 |=> ioGrant && !cpGrant)
		else $error("io claim not granted first");

	a_cp_alone: assert property (
		r_ff.state == ST_IDLE && !r_ff.ioReqS2 && r_ff.cpReqS2 |=> cpGrant)
		else $error("lone central claim not granted");

	a_cp_cause: assert property (
		$rose(cpGrant) |-> $past(r_ff.cpReqS2) && !$past(r_ff.ioReqS2) && $past(r_ff.state) == ST_IDLE)
		else $error("central grant while io claim pending");

	a_grant_cause: assert property (
		$rose(ioGrant) |-> $past(r_ff.ioReqS2) && $past(r_ff.state) == ST_IDLE)
		else $error("io grant without claim");

	a_sync_delay: assert property (
		seq_quietIdle |=> !ioGrant && !cpGrant ##1 !ioGrant && !cpGrant)
		else $error("grant before synchronised claim");

	a_io_sync_depth: assert property ($rose(ioGrant) |-> $past(ioReq, 3))
		else $error("io grant sooner than three edges after claim");

	a_cp_sync_depth: assert property ($rose(cpGrant) |-> $past(cpReq, 3))
		else $error("central grant sooner than three edges after claim");

	a_bus_owner: assert property (cycleStart |-> (ioBusOwn ^ cpBusOwn))
		else $error("bus owner not unique during access");

	a_io_owner: assert property (ioGrant |-> ioBusOwn && !cpBusOwn && r_ff.ownerIo)
		else $error("io grant without io bus ownership");

	a_cp_owner: assert property (cpGrant |-> cpBusOwn && !ioBusOwn && !r_ff.ownerIo)
		else $error("central grant without central bus ownership");

	// ----------------------------------------
	// memory cycle
	// ----------------------------------------
	a_wait_launch: assert property (
		r_ff.state == ST_GRANT && !ownLaunch |=> !cycleStart && r_ff.state == ST_GRANT)
		else $error("cycle started without launch");

	a_launch_start: assert property (
		seq_launchTaken |=> cycleStart && $onehot(modSelect) && cellIndex == $past(srcAddrChk[CELL_W-1:0]))
		else $error("launch not forwarded to one module");

	a_write_copy: assert property (
		seq_launchTaken |=> writeOp == $past(r_ff.ownerIo ? ioWrite : cpWrite))
		else $error("operation not taken from owner");

	a_cell_split: assert property (
		seq_launchTaken |=> sysCellHit == ($past(srcAddrChk) < RESERVED_CELLS))
		else $error("system cell flag wrong");

	a_fault_raise: assert property (
		seq_launchFault |=> addrFault && !cycleStart && modSelect == RST_MODSEL)
		else $error("unmapped launch not flagged");

	a_fault_pulse: assert property (
		addrFault |=> !addrFault && !ioGrant && !cpGrant)
		else $error("fault not a one-cycle pulse");

	a_select_idle: assert property (!cycleStart |-> modSelect == RST_MODSEL)
		else $error("module selected outside a cycle");

	a_cycle_stable: assert property (
		cycleStart && !r_ff.doneS2 |=> $stable(modSelect) && $stable(cellIndex) && $stable(writeOp))
		else $error("cycle fields changed during access");

	a_hold_owner: assert property (
		cycleStart && !r_ff.doneS2 |=> cycleStart && $stable(ioGrant) && $stable(cpGrant))
		else $error("grant changed during access");

	// ----------------------------------------
	// release
	// ----------------------------------------
	a_done_ends: assert property (
		seq_memDone |=> !cycleStart ##1 (!ioGrant && !cpGrant))
		else $error("access not closed after done");

	a_release_hold: assert property (
		seq_releaseHeld |=> r_ff.state == ST_RELEASE && (ioBusOwn || cpBusOwn))
		else $error("bus freed while handshake still active");

	a_bus_release: assert property (
		$fell(ioBusOwn) || $fell(cpBusOwn) |-> $past(r_ff.state) == ST_RELEASE && !$past(ownReq))
		else $error("bus freed outside release");

	a_idle_quiet: assert property (
		r_ff.state == ST_IDLE |-> !ioGrant && !cpGrant && !ioBusOwn && !cpBusOwn && !cycleStart && !sysCellHit)
		else $error("outputs active while idle");

endmodule
`default_nettype wire

// ### maa_pkg.sv
// Purpose: shared constants of the memory access arbiter
// Assumes: 17-bit cell address, up to sixteen 8,192-cell modules
// Notes: msb of an address vector is the leftmost bit, bit 0 of the field
package maa_pkg;

	// ----------------------------------------
	// address layout
	// ----------------------------------------
	localparam int ADDR_W = 17;
	localparam int MOD_W = 4;
	localparam int CELL_W = 13;
	localparam int NUM_MODULES = 16;
	localparam int CELLS_PER_MODULE = 8192;
	localparam int MOD_LSB = CELL_W;
	localparam int MOD_MSB = ADDR_W - 1;
	localparam logic [ADDR_W-1:0] RESERVED_CELLS = 17'h00100;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [NUM_MODULES-1:0] RST_MODSEL = 16'h0000;
	localparam logic [CELL_W-1:0] RST_CELL = 13'h0000;

	// ----------------------------------------
	// arbiter states, one-hot
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_GRANT = 4'b0010,
		ST_BUSY = 4'b0100,
		ST_RELEASE = 4'b1000
	} maa_state_e;

endpackage

// ### memory_access_arbiter_test.sv
// Purpose: self-checking bench of the memory access arbiter
// Assumes: io base 3 allow all, cp base 0 without module 15, physical module 15 absent
// Notes: index 1 is io_processor, 0 is central_processor
`timescale 1ns/1ps
`default_nettype none
module memory_access_arbiter_test;
	import maa_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] req = 2'b00, launch = 2'b00, wr = 2'b00;
	logic [ADDR_W-1:0] addr [2] = '{17'h00000, 17'h00000};
	logic slow = 1'b0;
	logic [NUM_MODULES-1:0] present = 16'h7fff;
	logic memDone, cycleStart, writeOp, sysCellHit, addrFault, ioGrant, cpGrant, ioBusOwn, cpBusOwn;
	logic [NUM_MODULES-1:0] modSelect;
	logic [CELL_W-1:0] cellIndex;
	wire [1:0] grant = {ioGrant, cpGrant};
	wire [1:0] busOwn = {ioBusOwn, cpBusOwn};
	int num_errors = 0, total_checks = 0, cycles = 0, n, p;
	logic [31:0] seed = 32'h70c3e11d;
	always #10 ref_clk = ~ref_clk;
	maa_memory_access_arbiter dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.ioReq(req[1]), .ioLaunch(launch[1]), .ioWrite(wr[1]), .ioAddr(addr[1]), .ioModBase(4'h3),
		.ioModAllow(16'hffff), .ioGrant(ioGrant), .ioBusOwn(ioBusOwn),
		.cpReq(req[0]), .cpLaunch(launch[0]), .cpWrite(wr[0]), .cpAddr(addr[0]), .cpModBase(4'h0),
		.cpModAllow(16'h7fff), .cpGrant(cpGrant), .cpBusOwn(cpBusOwn),
		.modPresent(present), .memDone(memDone), .modSelect(modSelect), .cellIndex(cellIndex),
		.cycleStart(cycleStart), .writeOp(writeOp), .sysCellHit(sysCellHit), .addrFault(addrFault));
	maa_mem_model mem (.ref_clk(ref_clk), .rst_n(rst_n), .cycleStart(cycleStart), .slow(slow),
		.memDone(memDone));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// expected physical module: logical module plus the strapped base, mod 16
	function automatic logic [3:0] physOf(input int p, input logic [ADDR_W-1:0] a);
		return a[16:13] + (p == 1 ? 4'h3 : 4'h0);
	endfunction
	task automatic chkFlag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one whole access by processor p, claim already raised
	task automatic serve(input int p, input logic [ADDR_W-1:0] a, input logic w, input int pace);
		int i;
		logic [3:0] phys;
		logic f;
		phys = physOf(p, a);
		f = ((p == 0) && (a[16:13] == 4'hf)) || !present[phys];
		for (i = 0; i < 20 && grant[p] !== 1'b1; i++) @(negedge ref_clk);
		chkVal(grant, p == 1 ? 2'b10 : 2'b01);
		chkFlag(busOwn[p], 1'b1);
		repeat (pace) @(negedge ref_clk);
		chkFlag(cycleStart, 1'b0);
		addr[p] = a;
		wr[p] = w;
		launch[p] = 1'b1;
		for (i = 0; i < 20 && cycleStart !== 1'b1 && addrFault !== 1'b1; i++) @(negedge ref_clk);
		chkFlag(addrFault, f);
		if (!f) begin
			chkVal(modSelect, 16'h0001 << phys);
			chkVal(cellIndex, a[12:0]);
			chkFlag(writeOp, w);
			chkFlag(sysCellHit, a < RESERVED_CELLS);
		end
		for (i = 0; i < 30 && grant[p] === 1'b1; i++) @(negedge ref_clk);
		chkVal({cycleStart, modSelect}, 17'h00000);
		req[p] = 1'b0;
		launch[p] = 1'b0;
		for (i = 0; i < 20 && busOwn !== 2'b00; i++) @(negedge ref_clk);
		chkVal({busOwn, grant}, 4'h0);
		chkFlag(sysCellHit, 1'b0);
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			results;
		end
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chkVal({grant, busOwn, cycleStart}, 5'h00);
		// both claim together, then a doubleword across a module edge
		req = 2'b11;
		serve(1, 17'h000a5, 1'b1, 0);
		serve(0, 17'h01fff, 1'b0, 2);
		req[0] = 1'b1;
		serve(0, 17'h02000, 1'b1, 0);
		// cp barred from module 15
		req[0] = 1'b1;
		serve(0, 17'h1e010, 1'b0, 1);
		// io to logical module 12 lands on absent physical module 15
		req[1] = 1'b1;
		serve(1, 17'h18000, 1'b1, 0);
		for (n = 0; n < 16; n++) begin
			seed = lfsr(seed);
			p = seed[0];
			slow = seed[5];
			req[p] = 1'b1;
			req[~p & 1] = seed[6];
			// on a joint claim the io_processor is served first
			p = req[1] ? 1 : 0;
			serve(p, seed[22:6], seed[1], seed[3:2]);
			if (req !== 2'b00) serve(req[1] ? 1 : 0, ~seed[22:6], seed[2], 0);
		end
		results;
	end
endmodule
`default_nettype wire
